// *** serial_port_config.sv ***
`include "serial_port_consts.svh"

module serial_port_config
	import serial_port_pkg::*;
#(
	parameter int CLK_HZ = `CLK_HZ
) (
	input wire logic ref_clk, // 25 MHz clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire cmd_hdr_t cmd_hdr, // Main port command address from framer
	input wire logic tx_req, // Main port framer wants to transmit
	output logic cmd_exec, // Pulse: execute command
	output logic cmd_reply, // Pulse: answer may be sent
	output logic tx_oe, // Main transmit driver enable
	output logic rx_en, // Main receiver enable
	output logic main_tick, // 16x main baud enable
	output logic fb_tick, // 16x fieldbus baud enable
	output main_cfg_t main_cfg, // Main port configuration
	output fb_cfg_t fb_cfg, // Fieldbus configuration
	output logic line_termination // Drives 120 ohm termination switch
);

	// ==========================================
	// Configuration registers
	main_cfg_t main_q, main_d;
	fb_cfg_t fb_q, fb_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] drop_cnt_q, drop_cnt_d;
	logic [7:0] exec_cnt_q, exec_cnt_d;
	logic rejected_q, rejected_d;
	logic dropped;

	always_comb begin
		main_d = main_q;
		fb_d = fb_q;
		// A refusal in the clearing read cycle still sets the flag
		rejected_d = rejected_q && !(reg_rd && reg_addr == `REG_STATUS);
		if (reg_wr) begin
			case (reg_addr)
				`REG_MAIN_CFG: begin
					// Reserved mode code 3 is refused; mode keeps its value
					if (reg_wdata[`MAIN_MODE_LSB+:2] != 2'h3) begin
						main_d.mode = xcvr_mode_t'(reg_wdata[`MAIN_MODE_LSB+:2]);
					end else begin
						rejected_d = 1'b1;
					end
					main_d.baud_sel = reg_wdata[`MAIN_BAUD_LSB+:3];
					main_d.line_termination = reg_wdata[`MAIN_TERM_BIT];
				end
				`REG_MAIN_ADDR: begin
					// Address 00 cannot be stored as own address
					if (reg_wdata[7:0] != `ADDR_GLOBAL) begin
						main_d.bus_addr = reg_wdata[7:0];
					end else begin
						rejected_d = 1'b1;
					end
				end
				`REG_FB_CFG: begin
					if (reg_wdata[`FB_BAUD_LSB+:3] <= `FB_BAUD_MAX) begin
						fb_d.baud_sel = reg_wdata[`FB_BAUD_LSB+:3];
					end else begin
						rejected_d = 1'b1;
					end
					if (reg_wdata[`FB_PAR_LSB+:2] != 2'h3) begin
						fb_d.parity = parity_t'(reg_wdata[`FB_PAR_LSB+:2]);
					end else begin
						rejected_d = 1'b1;
					end
					fb_d.two_stop = reg_wdata[`FB_STOP_BIT];
				end
				`REG_FB_ID: begin
					if (reg_wdata[7:0] >= `FB_ID_MIN && reg_wdata[7:0] <= `FB_ID_MAX) begin
						fb_d.dev_id = reg_wdata[7:0];
					end else begin
						rejected_d = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================
	// Read path
	always_comb begin
		rdata_d = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				`REG_MAIN_CFG: begin
					rdata_d[`MAIN_MODE_LSB+:2] = main_q.mode;
					rdata_d[`MAIN_BAUD_LSB+:3] = main_q.baud_sel;
					rdata_d[`MAIN_TERM_BIT] = main_q.line_termination;
				end
				`REG_MAIN_ADDR: rdata_d[7:0] = main_q.bus_addr;
				`REG_FB_CFG: begin
					rdata_d[`FB_BAUD_LSB+:3] = fb_q.baud_sel;
					rdata_d[`FB_PAR_LSB+:2] = fb_q.parity;
					rdata_d[`FB_STOP_BIT] = fb_q.two_stop;
				end
				`REG_FB_ID: rdata_d[7:0] = fb_q.dev_id;
				`REG_STATUS: begin
					rdata_d[7:0] = exec_cnt_q;
					rdata_d[15:8] = drop_cnt_q;
					rdata_d[16] = rejected_q;
				end
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	// ==========================================
	// Activity counters (wrap), reset on status read
	always_comb begin
		exec_cnt_d = exec_cnt_q;
		drop_cnt_d = drop_cnt_q;
		if (reg_rd && reg_addr == `REG_STATUS) begin
			exec_cnt_d = 8'h00;
			drop_cnt_d = 8'h00;
		end
		// A new event in the read cycle is counted, not lost
		if (cmd_exec) begin
			exec_cnt_d = (reg_rd && reg_addr == `REG_STATUS) ? 8'h01 : exec_cnt_q + 8'h01;
		end
		if (dropped) begin
			drop_cnt_d = (reg_rd && reg_addr == `REG_STATUS) ? 8'h01 : drop_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			main_q.mode <= XCVR_OFF;
			main_q.baud_sel <= `RST_MAIN_BAUD;
			main_q.line_termination <= 1'b0;
			main_q.bus_addr <= `RST_MAIN_ADDR;
			fb_q.dev_id <= `RST_FB_ID;
			fb_q.baud_sel <= `RST_FB_BAUD;
			fb_q.parity <= PAR_NONE;
			fb_q.two_stop <= `RST_FB_STOP;
			rejected_q <= 1'b0;
		end else begin
			main_q <= main_d;
			fb_q <= fb_d;
			rejected_q <= rejected_d;
		end
	end

	// Read data register: zero outside the cycle after a read
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Activity counters
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			exec_cnt_q <= 8'h00;
			drop_cnt_q <= 8'h00;
		end else begin
			exec_cnt_q <= exec_cnt_d;
			drop_cnt_q <= drop_cnt_d;
		end
	end

	// ==========================================
	// Address filtering and line control
	addr_filter u_filter (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.mode(main_q.mode),
		.own_addr(main_q.bus_addr),
		.hdr(cmd_hdr),
		.accept(cmd_exec),
		.reply_ok(cmd_reply),
		.dropped(dropped)
	);

	baud_divider #(.CLK_HZ(CLK_HZ)) u_main_baud (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.baud_sel(main_q.baud_sel),
		.tick(main_tick)
	);

	// Fieldbus codes start at 2400, one step above the main table
	baud_divider #(.CLK_HZ(CLK_HZ)) u_fb_baud (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.baud_sel(fb_q.baud_sel + 3'h1),
		.tick(fb_tick)
	);

	assign rx_en = (main_q.mode != XCVR_OFF);
	assign tx_oe = tx_req && (main_q.mode != XCVR_OFF);
	// Termination only in multidrop protects the point-to-point driver
	assign line_termination = main_q.line_termination && (main_q.mode == XCVR_MULTIDROP);
	assign main_cfg = main_q;
	assign fb_cfg = fb_q;
	assign reg_rdata = rdata_q;

endmodule

// *** serial_port_consts.svh ***
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// ==========================================
// Register offsets (byte addresses, word spaced)
`define REG_MAIN_CFG 8'h00
`define REG_MAIN_ADDR 8'h04
`define REG_FB_CFG 8'h08
`define REG_FB_ID 8'h0C
`define REG_STATUS 8'h10

// ==========================================
// Field positions in REG_MAIN_CFG
`define MAIN_MODE_LSB 0
`define MAIN_BAUD_LSB 2
`define MAIN_TERM_BIT 5
// Field positions in REG_FB_CFG
`define FB_BAUD_LSB 0
`define FB_PAR_LSB 3
`define FB_STOP_BIT 5

// ==========================================
// Reset values, broadcast address and write limits
`define RST_MAIN_MODE 2'h0
`define RST_MAIN_BAUD 3'h3
`define RST_MAIN_ADDR 8'h11
`define RST_FB_ID 8'h0B
`define RST_FB_BAUD 3'h2
`define RST_FB_PAR 2'h0
`define RST_FB_STOP 1'h1
`define ADDR_GLOBAL 8'h00
`define FB_ID_MIN 8'h01
`define FB_ID_MAX 8'hF7
`define FB_BAUD_MAX 3'h6

// ==========================================
// Timing
`define CLK_HZ 25000000
`define BAUD_TABLE_1200 1200
`define BAUD_TABLE_2400 2400
`define BAUD_TABLE_4800 4800
`define BAUD_TABLE_9600 9600
`define BAUD_TABLE_19200 19200
`define BAUD_TABLE_38400 38400
`define BAUD_TABLE_57600 57600
`define BAUD_TABLE_115200 115200

`endif

// *** serial_port_pkg.sv ***
package serial_port_pkg;

	typedef enum logic [1:0] {
		XCVR_OFF = 2'h0,
		XCVR_P2P = 2'h1,
		XCVR_MULTIDROP = 2'h2
	} xcvr_mode_t;

	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_ODD = 2'h1,
		PAR_EVEN = 2'h2
	} parity_t;

	typedef struct packed {
		xcvr_mode_t mode;
		logic [2:0] baud_sel;
		logic line_termination;
		logic [7:0] bus_addr;
	} main_cfg_t;

	typedef struct packed {
		logic [7:0] dev_id;
		logic [2:0] baud_sel;
		parity_t parity;
		logic two_stop;
	} fb_cfg_t;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
	} cmd_hdr_t;

endpackage

// *** baud_divider.sv ***
`include "serial_port_consts.svh"

module baud_divider
	import serial_port_pkg::*;
#(
	parameter int CLK_HZ = `CLK_HZ
) (
	input wire logic ref_clk, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic [2:0] baud_sel, // Rate code 0=1200 .. 7=115200
	output logic tick // One-cycle pulse at 16x baud
);

	localparam int DIV_WIDTH = 16;

	// ==========================================
	// Oversample divisors, one per rate code
	function automatic logic [DIV_WIDTH-1:0] div_of(input logic [2:0] sel);
		int rate;
		case (sel)
			3'h0: rate = `BAUD_TABLE_1200;
			3'h1: rate = `BAUD_TABLE_2400;
			3'h2: rate = `BAUD_TABLE_4800;
			3'h3: rate = `BAUD_TABLE_9600;
			3'h4: rate = `BAUD_TABLE_19200;
			3'h5: rate = `BAUD_TABLE_38400;
			3'h6: rate = `BAUD_TABLE_57600;
			default: rate = `BAUD_TABLE_115200;
		endcase
		// Rounded down; at 115200 the divisor is 13 and the rate runs about four percent fast
		div_of = DIV_WIDTH'(CLK_HZ / (rate * 16));
	endfunction

	logic [DIV_WIDTH-1:0] cnt_q, cnt_d;
	logic tick_q, tick_d;
	logic [2:0] sel_q, sel_d;

	always_comb begin
		sel_d = baud_sel;
		tick_d = 1'b0;
		cnt_d = cnt_q + 16'h0001;
		// A rate change restarts the count so no stale long period runs out
		if (sel_q != baud_sel || cnt_q >= div_of(baud_sel) - 16'h0001) begin
			cnt_d = 16'h0000;
			tick_d = (sel_q == baud_sel);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_q <= 16'h0000;
			tick_q <= 1'b0;
			sel_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
			sel_q <= sel_d;
		end
	end

	assign tick = tick_q;

endmodule

// *** addr_filter.sv ***
`include "serial_port_consts.svh"

module addr_filter
	import serial_port_pkg::*;
(
	input wire logic ref_clk, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire xcvr_mode_t mode, // Transceiver mode
	input wire logic [7:0] own_addr, // Configured bus address
	input wire cmd_hdr_t hdr, // Address of a received command
	output logic accept, // Pulse: execute command
	output logic reply_ok, // Pulse, with accept: reply allowed
	output logic dropped // Pulse: command ignored
);

	logic accept_q, accept_d;
	logic reply_q, reply_d;
	logic drop_q, drop_d;

	always_comb begin
		accept_d = 1'b0;
		reply_d = 1'b0;
		drop_d = 1'b0;
		if (hdr.valid) begin
			case (mode)
				XCVR_P2P: begin
					accept_d = 1'b1;
					reply_d = 1'b1;
				end
				XCVR_MULTIDROP: begin
					if (hdr.addr == `ADDR_GLOBAL) begin
						accept_d = 1'b1;
					end else if (hdr.addr == own_addr) begin
						accept_d = 1'b1;
						reply_d = 1'b1;
					end else begin
						drop_d = 1'b1;
					end
				end
				default: begin
					drop_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			accept_q <= 1'b0;
			reply_q <= 1'b0;
			drop_q <= 1'b0;
		end else begin
			accept_q <= accept_d;
			reply_q <= reply_d;
			drop_q <= drop_d;
		end
	end

	assign accept = accept_q;
	assign reply_ok = reply_q;
	assign dropped = drop_q;

endmodule

// *** serial_port_config_asserts.sv ***
module serial_port_config_asserts
	import serial_port_pkg::*;
(
	input wire logic ref_clk, // Clock
	input wire logic sys_rst, // Reset
	input wire cmd_hdr_t cmd_hdr, // Command address
	input wire logic cmd_exec, // Execute pulse
	input wire logic cmd_reply, // Reply pulse
	input wire logic tx_oe, // Driver enable
	input wire logic rx_en, // Receiver enable
	input wire main_cfg_t main_cfg, // Main settings
	input wire fb_cfg_t fb_cfg, // Fieldbus settings
	input wire logic line_termination // Resistor switch
);
	// ==========================================
	// Properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic md;
	logic hv;
	logic p2p;
	logic idle;
	logic bcast;
	logic own;
	logic stray;
	logic term_bit;
	main_cfg_t main_rst;
	fb_cfg_t fb_rst;
	assign md = main_cfg.mode == XCVR_MULTIDROP;
	assign p2p = main_cfg.mode == XCVR_P2P;
	assign idle = main_cfg.mode == XCVR_OFF;
	assign hv = cmd_hdr.valid;
	assign bcast = cmd_hdr.addr == 8'h00;
	assign own = cmd_hdr.addr == main_cfg.bus_addr;
	assign stray = md && !own && !bcast;
	assign term_bit = main_cfg.line_termination;
	// Factory values: off, 9600, no termination, address 11 hex
	assign main_rst = '{XCVR_OFF, 3'h3, 1'b0, 8'h11};
	// Fieldbus: ID 11, 9600, no parity, two stop bits
	assign fb_rst = '{8'h0B, 3'h2, PAR_NONE, 1'b1};
	main_reset_a: assert property ($fell(sys_rst) |-> main_cfg == main_rst)
		else $error("main settings reset value wrong");
	fb_reset_a: assert property ($fell(sys_rst) |-> fb_cfg == fb_rst)
		else $error("fieldbus settings reset value wrong");
	off_quiet_a: assert property (idle |-> !tx_oe && !rx_en)
		else $error("disabled port drives or listens");
	off_drop_a: assert property (hv && idle |=> !cmd_exec)
		else $error("disabled port executed a command");
	p2p_answer_a: assert property (hv && p2p |=> cmd_exec && cmd_reply)
		else $error("point-to-point command not answered");
	bcast_quiet_a: assert property (hv && md && bcast |=> cmd_exec && !cmd_reply)
		else $error("broadcast handled wrongly");
	own_addr_a: assert property (hv && md && own |=> cmd_exec && cmd_reply)
		else $error("own address command not answered");
	foreign_drop_a: assert property (hv && stray |=> !cmd_exec && !cmd_reply)
		else $error("foreign command acted on");
	term_gate_a: assert property (line_termination == (term_bit && md))
		else $error("termination switch wrong");
	reply_pair_a: assert property (cmd_reply |-> cmd_exec && $past(hv))
		else $error("reply without command");
	cover property (cmd_exec && cmd_reply);
	cover property (cmd_exec && !cmd_reply);
	cover property (hv && stray);
	cover property (line_termination);
endmodule

bind serial_port_config serial_port_config_asserts chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.cmd_hdr(cmd_hdr), .cmd_exec(cmd_exec), .cmd_reply(cmd_reply), .tx_oe(tx_oe), .rx_en(rx_en),
	.main_cfg(main_cfg), .fb_cfg(fb_cfg), .line_termination(line_termination));

// *** host_model.sv ***
module host_model
	import serial_port_pkg::*;
(
	input wire logic ref_clk, // Clock
	output cmd_hdr_t cmd_hdr, // Command address to the block
	output logic tx_req // Wish to transmit
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_hdr = '0;
		tx_req = 1'b0;
	end
	// Headers arrive already framed, each valid for one clock cycle
	// Released address shows the inverse so a stale value never matches
	task automatic send(input logic [7:0] a);
		@(posedge ref_clk);
		cmd_hdr <= '{1'b1, a};
		@(posedge ref_clk);
		cmd_hdr <= '{1'b0, ~a};
	endtask
	task automatic hold(input logic v);
		@(posedge ref_clk);
		tx_req <= v;
	endtask
endmodule

// *** serial_port_config_bench.sv ***
`include "serial_port_consts.svh"

module serial_port_config_bench
	import serial_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	cmd_hdr_t cmd_hdr;
	logic tx_req, cmd_exec, cmd_reply, tx_oe, rx_en, main_tick, fb_tick, line_termination;
	main_cfg_t main_cfg;
	fb_cfg_t fb_cfg;
	int n_errors = 0;
	int comparisons = 0;
	always #20 ref_clk = ~ref_clk;
	host_model host (.ref_clk(ref_clk), .cmd_hdr(cmd_hdr), .tx_req(tx_req));
	serial_port_config dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cmd_hdr(cmd_hdr), .tx_req(tx_req), .cmd_exec(cmd_exec), .cmd_reply(cmd_reply),
		.tx_oe(tx_oe), .rx_en(rx_en), .main_tick(main_tick), .fb_tick(fb_tick),
		.main_cfg(main_cfg), .fb_cfg(fb_cfg), .line_termination(line_termination));
	// ==========================================
	// Bus and compare tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
	endtask
	task cmd(input logic [7:0] a, input logic ex, input logic rp);
		host.send(a);
		#1 chk("exec_reply", {30'h0, ex, rp}, {30'h0, cmd_exec, cmd_reply});
	endtask
	// Cycles between two rate pulses; a missing pulse reads as a mismatch
	task tick_gap(input logic fb, input int e);
		int first;
		int gap;
		first = -1;
		gap = -1;
		for (int i = 0; i < 2000 && gap < 0; i++) begin
			@(posedge ref_clk);
			#1;
			if (fb ? fb_tick : main_tick) begin
				if (first < 0) begin
					first = i;
				end else begin
					gap = i - first;
				end
			end
		end
		if (fb) begin
			chk("fb_tick", 32'(e), 32'(gap));
		end else begin
			chk("main_tick", 32'(e), 32'(gap));
		end
	endtask
	// ==========================================
	// Scenarios
	task t_reset;
		rc(8'h00, 32'h0000000C);
		rc(8'h04, 32'h00000011);
		rc(8'h08, 32'h00000022);
		rc(8'h0C, 32'h0000000B);
		tick_gap(1'b0, `CLK_HZ / (`BAUD_TABLE_9600 * 16));
		tick_gap(1'b1, `CLK_HZ / (`BAUD_TABLE_9600 * 16));
		host.hold(1'b1);
		cmd(8'h11, 1'b0, 1'b0);
		chk("oe_en", 32'h0, {30'h0, tx_oe, rx_en});
		$display("test reset done");
	endtask
	task t_main;
		for (int m = 0; m < 3; m++) begin
			for (int b = 0; b < 8; b++) begin
				wr(8'h00, 32'(b * 4 + m));
				rc(8'h00, 32'(b * 4 + m));
			end
		end
		wr(8'h00, 32'h0000001F);
		rc(8'h00, 32'h0000001E);
		tick_gap(1'b0, `CLK_HZ / (`BAUD_TABLE_115200 * 16));
		$display("test main settings done");
	endtask
	task t_p2p;
		wr(8'h00, 32'h0000000D);
		cmd(8'h55, 1'b1, 1'b1);
		chk("oe_en", 32'h3, {30'h0, tx_oe, rx_en});
		$display("test point-to-point done");
	endtask
	task t_multi;
		wr(8'h00, 32'h0000002E);
		#1 chk("term", 32'h1, {31'h0, line_termination});
		cmd(8'h11, 1'b1, 1'b1);
		cmd(8'h00, 1'b1, 1'b0);
		cmd(8'h12, 1'b0, 1'b0);
		rc(8'h10, 32'h00010203);
		rc(8'h10, 32'h00000000);
		wr(8'h04, 32'h000000FF);
		cmd(8'hFF, 1'b1, 1'b1);
		wr(8'h04, 32'h00000000);
		rc(8'h04, 32'h000000FF);
		wr(8'h00, 32'h0000000E);
		#1 chk("term", 32'h0, {31'h0, line_termination});
		$display("test multidrop done");
	endtask
	task t_fb;
		wr(8'h0C, 32'h00000001);
		rc(8'h0C, 32'h00000001);
		wr(8'h0C, 32'h000000F7);
		wr(8'h0C, 32'h000000F8);
		rc(8'h0C, 32'h000000F7);
		wr(8'h0C, 32'h00000000);
		rc(8'h0C, 32'h000000F7);
		wr(8'h08, 32'h00000006);
		rc(8'h08, 32'h00000006);
		tick_gap(1'b1, `CLK_HZ / (`BAUD_TABLE_115200 * 16));
		wr(8'h08, 32'h0000000E);
		rc(8'h08, 32'h0000000E);
		wr(8'h08, 32'h00000016);
		wr(8'h08, 32'h0000001E);
		rc(8'h08, 32'h00000016);
		wr(8'h08, 32'h00000017);
		rc(8'h08, 32'h00000016);
		rc(8'h10, 32'h00010001);
		$display("test fieldbus done");
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Hang guard far beyond the fewer than a thousand cycles the run needs
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_main();
		t_p2p();
		t_multi();
		t_fb();
		print_verdict();
	end
endmodule
